/* File: inc/rte_defs.svh */
// Register map, field positions and reset values of the reload event timer
`ifndef RTE_DEFS_SVH
`define RTE_DEFS_SVH

// ----------------------------------------
// Addresses
// ----------------------------------------
`define RTE_ADDR_W 16
`define RTE_DATA_W 16
`define RTE_CSR_ADDR 16'h0066
`define RTE_CNT_ADDR 16'h3900

// ----------------------------------------
// Control/status fields
// ----------------------------------------
`define RTE_BIT_TRG 0
`define RTE_BIT_OPERATION_ENABLE 1
`define RTE_BIT_UF 2
`define RTE_BIT_UNDERFLOW_IRQ_ENABLE 3
`define RTE_BIT_RELOAD_SELECT 4
`define RTE_BIT_OUTPUT_LEVEL_SELECT 5
`define RTE_MOD_LSB 7
`define RTE_MOD_MSB 9
`define RTE_CSL_LSB 10
`define RTE_CSL_MSB 11

// ----------------------------------------
// Values
// ----------------------------------------
`define RTE_CSL_EVENT 2'h3
`define RTE_MOD_RISE 3'h1
`define RTE_MOD_FALL 3'h2
`define RTE_MOD_BOTH 3'h3
`define RTE_CNT_ZERO 16'h0000
`define RTE_CNT_ONES 16'hffff
`define RTE_RST16 16'h0000

`endif

/* File: inc/rte_pkg.sv */
// Types shared by the reload event timer
package rte_pkg;

  // ----------------------------------------
  // Register port request
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } rte_bus_req_t;

  // ----------------------------------------
  // Stored control fields
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] count_source_sel;
    logic [2:0] mode_select;
    logic output_level_select;
    logic reload_select;
    logic underflow_irq_enable;
    logic underflow_flag;
    logic operation_enable;
  } rte_ctrl_t;

endpackage

/* File: rtl/rte_timer.sv */
// Sixteen-bit reload timer in event count mode, with register port
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "rte_defs.svh"

module rte_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input rte_pkg::rte_bus_req_t bus_i,
  output logic [15:0] rdata_o,
  input wire logic event_input_pin_i,
  input wire logic xfer_ack_i,
  output logic wave_output_pin_o,
  output logic irq_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic edge_sel(input logic [2:0] mode, input logic rise,
                                    input logic fall);
    case (mode)
      `RTE_MOD_RISE: edge_sel = rise;
      `RTE_MOD_FALL: edge_sel = fall;
      `RTE_MOD_BOTH: edge_sel = rise | fall;
      default: edge_sel = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  rte_pkg::rte_ctrl_t ctrl;
  rte_pkg::rte_ctrl_t next_ctrl;
  logic [15:0] down_counter;
  logic [15:0] next_down_counter;
  logic [15:0] reload_value;
  logic running;
  logic next_running;
  logic next_wave;
  logic ev_s1;
  logic ev_s2;
  logic ev_s3;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic csr_hit = bus_i.addr == `RTE_CSR_ADDR;
  wire logic cnt_hit = bus_i.addr == `RTE_CNT_ADDR;
  wire logic csr_wr = bus_i.we & csr_hit;
  wire logic rld_wr = bus_i.we & cnt_hit;
  wire logic wr_operation_enable = bus_i.wdata[`RTE_BIT_OPERATION_ENABLE];
  // Trigger only starts when the same write leaves the timer enabled
  wire logic start = csr_wr & bus_i.wdata[`RTE_BIT_TRG] & wr_operation_enable;
  wire logic event_mode = ctrl.count_source_sel == `RTE_CSL_EVENT;
  wire logic ev_rise = ev_s2 & ~ev_s3;
  wire logic ev_fall = ~ev_s2 & ev_s3;
  wire logic ev_pulse = edge_sel(ctrl.mode_select, ev_rise, ev_fall);
  wire logic dec = running & ctrl.operation_enable & event_mode & ev_pulse;
  wire logic uflow = dec & (down_counter == `RTE_CNT_ZERO);
  wire logic [15:0] csr_rd = {4'h0, ctrl.count_source_sel, ctrl.mode_select, 1'b0,
                              ctrl.output_level_select, ctrl.reload_select,
                              ctrl.underflow_irq_enable, ctrl.underflow_flag,
                              ctrl.operation_enable, 1'b0};
  wire logic [15:0] rd_mux = csr_hit ? csr_rd : (cnt_hit ? down_counter : 16'h0000);

  // ----------------------------------------
  // Control register next value
  // ----------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    if (csr_wr) begin
      next_ctrl.count_source_sel = bus_i.wdata[`RTE_CSL_MSB:`RTE_CSL_LSB];
      next_ctrl.mode_select = bus_i.wdata[`RTE_MOD_MSB:`RTE_MOD_LSB];
      next_ctrl.output_level_select = bus_i.wdata[`RTE_BIT_OUTPUT_LEVEL_SELECT];
      next_ctrl.reload_select = bus_i.wdata[`RTE_BIT_RELOAD_SELECT];
      next_ctrl.underflow_irq_enable = bus_i.wdata[`RTE_BIT_UNDERFLOW_IRQ_ENABLE];
      next_ctrl.operation_enable = wr_operation_enable;
      // Writing zero clears the flag, writing one leaves it
      if (!bus_i.wdata[`RTE_BIT_UF]) begin
        next_ctrl.underflow_flag = 1'b0;
      end
    end
    if (xfer_ack_i) begin
      next_ctrl.underflow_flag = 1'b0;
    end
    // Set wins over any clear in the same cycle
    if (uflow) begin
      next_ctrl.underflow_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // Counter, run state and wave output
  // ----------------------------------------
  always_comb begin
    next_down_counter = down_counter;
    next_running = running & next_ctrl.operation_enable;
    next_wave = wave_output_pin_o;
    if (start) begin
      // Reload lands at the edge closing the trigger write
      next_down_counter = reload_value;
      next_running = 1'b1;
      if (next_ctrl.reload_select) begin
        next_wave = next_ctrl.output_level_select;
      end
    end else if (uflow) begin
      if (ctrl.reload_select) begin
        next_down_counter = reload_value;
        next_wave = ~wave_output_pin_o;
      end else begin
        next_down_counter = `RTE_CNT_ONES;
        next_running = 1'b0;
      end
    end else if (dec) begin
      next_down_counter = down_counter - 16'h0001;
    end
    if (!next_ctrl.reload_select) begin
      // Pulse is active while counting; level bit flips polarity
      next_wave = next_running ^ next_ctrl.output_level_select;
    end
  end

  // ----------------------------------------
  // Event input synchroniser
  // ----------------------------------------
  // The second and third stages feed the edge compare; four-cycle
  // minimum levels keep every edge visible
  always_ff @(posedge clk_i) begin
    ev_s1 <= event_input_pin_i;
    ev_s2 <= ev_s1;
    ev_s3 <= ev_s2;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      down_counter <= `RTE_RST16;
      reload_value <= `RTE_RST16;
      running <= 1'b0;
      wave_output_pin_o <= 1'b0;
      irq_o <= 1'b0;
      rdata_o <= `RTE_RST16;
    end else begin
      ctrl <= next_ctrl;
      down_counter <= next_down_counter;
      if (rld_wr) begin
        reload_value <= bus_i.wdata;
      end
      running <= next_running;
      wave_output_pin_o <= next_wave;
      irq_o <= next_ctrl.underflow_flag & next_ctrl.underflow_irq_enable;
      rdata_o <= bus_i.re ? rd_mux : 16'h0000;
    end
  end

endmodule

/* File: sim/rte_event_src.sv */
// Event pulse source driving the timer's event pin
`timescale 1ns/1ps
module rte_event_src (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  output logic pin_o,
  output logic busy_o
);
  logic [7:0] left = 8'h00;
  logic [1:0] tick = 2'h0;
  initial pin_o = 1'b0;
  assign busy_o = left != 8'h00;
  // Four cycles per level, the shortest width allowed
  always @(posedge clk_i) begin
    if (go_i) left <= n_i;
    else if (busy_o && tick == 2'h3) begin
      pin_o <= !pin_o;
      left <= left - 8'h01;
    end
    tick <= busy_o ? tick + 2'h1 : 2'h0;
  end
endmodule

/* File: sim/rte_timer_chk.sv */
// Port checks for the reload event timer
`timescale 1ns/1ps
`include "rte_defs.svh"
module rte_timer_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input rte_pkg::rte_bus_req_t bus_i,
  input wire logic [15:0] rdata_o,
  input wire logic event_input_pin_i,
  input wire logic xfer_ack_i,
  input wire logic wave_output_pin_o,
  input wire logic irq_o
);
  logic [3:0] idle;
  logic pin_q;
  // Cycles since the pin moved; outputs move only soon after
  always_ff @(posedge clk_i) begin
    pin_q <= event_input_pin_i;
    if (rst_i || pin_q != event_input_pin_i) idle <= {4{rst_i}};
    else if (idle != 4'hf) idle <= idle + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence csr_rd;
    $past(bus_i.re && bus_i.addr == `RTE_CSR_ADDR);
  endsequence
  sequence has_cause;
    $past(bus_i.we) || idle <= 4'h6;
  endsequence
  rd_idle_a: assert property (!$past(bus_i.re) |-> rdata_o == 16'h0000)
    else $error("stray read data");
  rd_unmap_a: assert property ($past(bus_i.re && bus_i.addr != `RTE_CSR_ADDR
    && bus_i.addr != `RTE_CNT_ADDR) |-> rdata_o == 16'h0000) else $error("unmapped read");
  csr_trig_a: assert property (csr_rd |-> !rdata_o[`RTE_BIT_TRG])
    else $error("trigger bit stored");
  csr_rsvd_a: assert property (csr_rd |-> rdata_o[15:12] == 4'h0 && !rdata_o[6])
    else $error("reserved bits set");
  irq_match_a: assert property (csr_rd |->
    (rdata_o[`RTE_BIT_UF] && rdata_o[`RTE_BIT_UNDERFLOW_IRQ_ENABLE]) == $past(irq_o)) else $error("irq level");
  irq_hold_a: assert property ($fell(irq_o) |-> $past(xfer_ack_i || bus_i.we))
    else $error("irq dropped");
  irq_cause_a: assert property ($rose(irq_o) |-> has_cause)
    else $error("irq without cause");
  wave_cause_a: assert property ($changed(wave_output_pin_o) |-> has_cause)
    else $error("wave without cause");
endmodule
bind rte_timer rte_timer_chk i_rte_timer_chk (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .event_input_pin_i(event_input_pin_i), .xfer_ack_i(xfer_ack_i),
  .wave_output_pin_o(wave_output_pin_o), .irq_o(irq_o));

/* File: sim/test_rte_timer.sv */
// Self-checking bench for the reload event timer
`timescale 1ns/1ps
`include "rte_defs.svh"
module test_rte_timer;
  localparam logic [15:0] cs_a = `RTE_CSR_ADDR;
  localparam logic [15:0] ct_a = `RTE_CNT_ADDR;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ack = 1'b0;
  logic go = 1'b0;
  logic [7:0] n = 8'h00;
  logic pin, busy, wave, irq;
  logic [15:0] rdata;
  rte_pkg::rte_bus_req_t bus = '0;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #20 clk_i = !clk_i;
  rte_timer i_rte_timer (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .event_input_pin_i(pin), .xfer_ack_i(ack), .wave_output_pin_o(wave), .irq_o(irq));
  rte_event_src i_rte_event_src (.clk_i(clk_i), .go_i(go), .n_i(n), .pin_o(pin), .busy_o(busy));
  task automatic chk(input string s, input logic [15:0] e, g);
    samples_checked++;
    if (e !== g) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic bus_op(input rte_pkg::rte_bus_req_t r);
    @(posedge clk_i);
    bus <= r;
    @(posedge clk_i);
    bus <= '0;
    #1;
  endtask
  task automatic wr(input logic [15:0] a, d);
    bus_op('{a, d, 1'b1, 1'b0});
  endtask
  task automatic rd(input logic [15:0] a, e, input string s);
    bus_op('{a, 16'h0000, 1'b0, 1'b1});
    chk(s, e, rdata);
  endtask
  task automatic ev(input logic [7:0] k);
    @(posedge clk_i);
    go <= 1'b1;
    n <= k;
    @(posedge clk_i);
    go <= 1'b0;
    #1;
    for (int i = 0; busy && i < 300; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (busy) begin
      n_mismatch++;
      test_done;
    end
    repeat (6) @(posedge clk_i);
  endtask
  function automatic logic [15:0] cw(input logic [2:0] m, input logic r, o);
    cw = {4'h0, `RTE_CSL_EVENT, m, 1'b0, o, r, 4'hb};
  endfunction
  task automatic start(input logic [15:0] r, w);
    wr(cs_a, 16'h0000);
    wr(ct_a, r);
    wr(cs_a, w);
  endtask
  task automatic one_shot;
    start(16'h0003, cw(`RTE_MOD_RISE, 1'b0, 1'b0));
    rd(ct_a, 16'h0003, "load");
    chk("pulse", 16'h0001, {15'h0, wave});
    ev(8'h08);
    rd(ct_a, 16'hffff, "under");
    chk("irq", 16'h0001, {15'h0, irq});
    chk("idle", 16'h0000, {15'h0, wave});
    rd(cs_a, 16'h0c8e, "flag");
    ev(8'h02);
    rd(ct_a, 16'hffff, "halt");
    wr(cs_a, 16'h0c8a);
    chk("clear", 16'h0000, {15'h0, irq});
    wr(cs_a, 16'h0c8b);
    rd(ct_a, 16'h0003, "again");
  endtask
  task automatic modes;
    logic [15:0] e [5] = '{16'h0010, 16'h000e, 16'h000f, 16'h000d, 16'h0010};
    for (int i = 0; i < 5; i++) begin
      start(16'h0010, cw(i == 4 ? 3'h1 : 3'(i), 1'b0, 1'b0) ^ (i == 4 ? 16'h0400 : 16'h0));
      ev(8'h03);
      rd(ct_a, e[i], "mode");
      ev(8'h01);
    end
  endtask
  task automatic reload;
    start(16'h0001, cw(`RTE_MOD_BOTH, 1'b1, 1'b1));
    chk("preset", 16'h0001, {15'h0, wave});
    ev(8'h02);
    rd(ct_a, 16'h0001, "reload");
    chk("toggle", 16'h0000, {15'h0, wave});
    @(posedge clk_i);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    #1;
    chk("ack", 16'h0000, {15'h0, irq});
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cs_a, 16'h0000, "csr");
    rd(16'h0002, 16'h0000, "unmapped");
    one_shot;
    modes;
    reload;
    test_done;
  end
endmodule
